// *** protect_pkg.sv ***
// Package of constants and types for the code read protection gate
package protect_pkg;

    // ------------------------------------------------------------
    // Protection patterns held in the dedicated flash word
    // ------------------------------------------------------------
    localparam logic [31:0] PAT_PARTIAL_UPDATE = 32'h12345678;
    localparam logic [31:0] PAT_FULL_ERASE_ONLY = 32'h87654321;
    localparam logic [31:0] PAT_LOCKED = 32'h43218765;
    localparam logic [31:0] PAT_NO_LOADER_ENTRY = 32'h4E697370;

    // ------------------------------------------------------------
    // Flash address of the pattern word, sector layout
    // ------------------------------------------------------------
    localparam logic [31:0] PAT_ADDR = 32'h000002FC;
    localparam int SECTOR_LSB = 12;
    localparam int SECTOR_W = 4;
    // Last count of the pin settle wait after the pattern is taken
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    // ------------------------------------------------------------
    // Loader command codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_UNLOCK = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h1;
    localparam logic [3:0] CMD_WRITE = 4'h2;
    localparam logic [3:0] CMD_PREPARE = 4'h3;
    localparam logic [3:0] CMD_ERASE = 4'h4;
    localparam logic [3:0] CMD_ERASE_ALL = 4'h5;
    localparam logic [3:0] CMD_GO = 4'h6;
    localparam logic [3:0] CMD_READ_ID = 4'h7;
    localparam logic [3:0] CMD_COPY_RAM = 4'h8;
    localparam logic [3:0] CMD_BLANK_CHECK = 4'h9;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LVL_NONE = 2'b00,
        LVL_PARTIAL = 2'b01,
        LVL_FULL_ERASE = 2'b10,
        LVL_LOCKED = 2'b11
    } level_t;

    typedef enum logic [1:0]
    {
        ST_FETCH = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10
    } state_t;

    typedef struct packed
    {
        logic [3:0] code;
        logic [3:0] sector;
        logic whole_chip;
    } loader_cmd_t;

endpackage : protect_pkg

// *** code_read_protection_gate.sv ***
// Flash access protection gate for debug port and loader paths
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Protection level comes from a pattern in a flash word; gates debug and loader access.
// - Application programming calls pass at every level, gated only by startup done.
// - Loader entry by boot select pin can be disabled alone.
// - Three protection levels exist beyond unprotected.
// - Level one: no debug; limited loader commands, sector 0 reached only by a whole-chip prepare.
// - Level two: no debug; besides unlock and read ID, only full erase then update allowed.
// - Level three: no debug, no loader, boot select pin ignored.
// - Level three still honours application calls, including loader re-entry.
// - Boot select pin low at the end of the settle wait after the pattern fetch starts loader when permitted.
module code_read_protection_gate
(
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    output logic PAT_RD_REQ,
    output logic [31:0] PAT_RD_ADDR,
    input wire logic PAT_RD_VALID,
    input wire logic [31:0] PAT_RD_DATA,
    input wire logic BOOT_SELECT_PIN,
    output logic DEBUG_ENABLE,
    output logic LOADER_START,
    output logic [1:0] PROTECT_LEVEL,
    output logic READY,
    input wire logic LOADER_CMD_VALID,
    input wire protect_pkg::loader_cmd_t LOADER_CMD,
    output logic LOADER_CMD_ACCEPT,
    output logic LOADER_CMD_REJECT,
    input wire logic IN_APPLICATION_PROGRAMMING_VALID,
    input wire logic IN_APPLICATION_PROGRAMMING_REINVOKE,
    output logic IN_APPLICATION_PROGRAMMING_ACCEPT
);

    // ------------------------------------------------------------
    // Boot select pin synchroniser, three stages
    // ------------------------------------------------------------
    logic [2:0] pin_sync_reg;
    logic [2:0] pin_sync_next;
    logic pin_level_reg;
    logic pin_level_next;

    // Shift in pin, accept change when last two stages agree
    always_comb
    begin
        pin_sync_next = {pin_sync_reg[1:0], BOOT_SELECT_PIN};
        pin_level_next = pin_level_reg;
        if (pin_sync_reg[2] == pin_sync_reg[1])
        begin
            pin_level_next = pin_sync_reg[2];
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            pin_sync_reg <= 3'h7;
            pin_level_reg <= 1'b1;
        end
        else
        begin
            pin_sync_reg <= pin_sync_next;
            pin_level_reg <= pin_level_next;
        end
    end

    // ------------------------------------------------------------
    // Pattern decode
    // ------------------------------------------------------------
    function automatic protect_pkg::level_t decode_level(input logic [31:0] pat);
        protect_pkg::level_t lvl;
        lvl = protect_pkg::LVL_NONE;
        unique case (pat)
            protect_pkg::PAT_PARTIAL_UPDATE: lvl = protect_pkg::LVL_PARTIAL;
            protect_pkg::PAT_FULL_ERASE_ONLY: lvl = protect_pkg::LVL_FULL_ERASE;
            protect_pkg::PAT_LOCKED: lvl = protect_pkg::LVL_LOCKED;
            default: lvl = protect_pkg::LVL_NONE; // Unknown is unprotected
        endcase
        return lvl;
    endfunction : decode_level

    // ------------------------------------------------------------
    // Startup sequence and level hold
    // ------------------------------------------------------------
    protect_pkg::state_t state_reg;
    protect_pkg::state_t state_next;
    protect_pkg::level_t level_reg;
    protect_pkg::level_t level_next;
    logic no_entry_reg;
    logic no_entry_next;
    logic start_reg;
    logic start_next;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;

    // Fetch pattern once, then sample pin after synchroniser settles
    always_comb
    begin
        state_next = state_reg;
        level_next = level_reg;
        no_entry_next = no_entry_reg;
        start_next = 1'b0;
        settle_next = settle_reg;
        unique case (state_reg)
            protect_pkg::ST_FETCH:
            begin
                if (PAT_RD_VALID) // Single read after reset
                begin
                    level_next = decode_level(PAT_RD_DATA);
                    no_entry_next = (PAT_RD_DATA == protect_pkg::PAT_NO_LOADER_ENTRY);
                    state_next = protect_pkg::ST_WAIT;
                end
            end
            protect_pkg::ST_WAIT:
            begin
                settle_next = settle_reg + 2'h1;
                if (settle_reg == protect_pkg::SETTLE_LAST)
                begin
                    // Pin low starts loader unless locked or disabled
                    start_next = !pin_level_reg && !no_entry_reg
                        && (level_reg != protect_pkg::LVL_LOCKED);
                    state_next = protect_pkg::ST_RUN;
                end
            end
            protect_pkg::ST_RUN:
            begin
                // Application may re-enter loader at any level
                start_next = IN_APPLICATION_PROGRAMMING_VALID && IN_APPLICATION_PROGRAMMING_REINVOKE;
            end
            default:
            begin
                state_next = protect_pkg::ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= protect_pkg::ST_FETCH;
            level_reg <= protect_pkg::LVL_NONE;
            no_entry_reg <= 1'b0;
            start_reg <= 1'b0;
            settle_reg <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            level_reg <= level_next;
            no_entry_reg <= no_entry_next;
            start_reg <= start_next;
            settle_reg <= settle_next;
        end
    end

    // ------------------------------------------------------------
    // Loader command filter
    // ------------------------------------------------------------
    logic allow;
    logic loader_on_reg;
    logic loader_on_next;
    logic erased_reg;
    logic erased_next;

    // Command permission per level
    always_comb
    begin
        allow = 1'b0;
        unique case (level_reg)
            protect_pkg::LVL_NONE: allow = 1'b1;
            protect_pkg::LVL_PARTIAL: // Sector 0 only in whole-chip prepare, no readback
                allow = ((LOADER_CMD.code == protect_pkg::CMD_WRITE)
                    || (LOADER_CMD.code == protect_pkg::CMD_PREPARE)
                    || (LOADER_CMD.code == protect_pkg::CMD_ERASE)
                    || (LOADER_CMD.code == protect_pkg::CMD_COPY_RAM)
                    || (LOADER_CMD.code == protect_pkg::CMD_UNLOCK)
                    || (LOADER_CMD.code == protect_pkg::CMD_READ_ID))
                    && (LOADER_CMD.whole_chip || (LOADER_CMD.sector != 4'h0))
                    && !(LOADER_CMD.whole_chip
                    && (LOADER_CMD.code != protect_pkg::CMD_PREPARE));
            protect_pkg::LVL_FULL_ERASE: // Whole erase first, then writes
                allow = (LOADER_CMD.code == protect_pkg::CMD_READ_ID)
                    || (LOADER_CMD.code == protect_pkg::CMD_UNLOCK)
                    || ((LOADER_CMD.code == protect_pkg::CMD_PREPARE
                    || LOADER_CMD.code == protect_pkg::CMD_ERASE_ALL)
                    && LOADER_CMD.whole_chip)
                    || (erased_reg && (LOADER_CMD.code == protect_pkg::CMD_WRITE
                    || LOADER_CMD.code == protect_pkg::CMD_COPY_RAM));
            protect_pkg::LVL_LOCKED: allow = 1'b0; // Loader refused
        endcase
        loader_on_next = loader_on_reg || start_reg;
        erased_next = erased_reg || (LOADER_CMD_VALID && allow && loader_on_reg
            && (LOADER_CMD.code == protect_pkg::CMD_ERASE_ALL));
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            loader_on_reg <= 1'b0;
            erased_reg <= 1'b0;
        end
        else
        begin
            loader_on_reg <= loader_on_next;
            erased_reg <= erased_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PAT_RD_REQ = (state_reg == protect_pkg::ST_FETCH) && !SYS_RST;
    assign PAT_RD_ADDR = protect_pkg::PAT_ADDR;
    assign READY = (state_reg == protect_pkg::ST_RUN);
    // Debug only when unprotected and startup done
    assign DEBUG_ENABLE = READY && (level_reg == protect_pkg::LVL_NONE);
    assign LOADER_START = start_reg;
    assign PROTECT_LEVEL = level_reg;
    // Loader path needs loader active and a permitting level
    assign LOADER_CMD_ACCEPT = LOADER_CMD_VALID && loader_on_reg && allow;
    assign LOADER_CMD_REJECT = LOADER_CMD_VALID && !(loader_on_reg && allow);
    // Application calls never gated by level
    assign IN_APPLICATION_PROGRAMMING_ACCEPT = IN_APPLICATION_PROGRAMMING_VALID && READY;

endmodule : code_read_protection_gate

`default_nettype wire

// *** code_read_protection_gate_sva.sv ***
// Checker for the code read protection gate
`timescale 1ns/100ps
`default_nettype none
module code_read_protection_gate_sva
(
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic PAT_RD_REQ,
    input wire logic PAT_RD_VALID,
    input wire logic [31:0] PAT_RD_DATA,
    input wire logic DEBUG_ENABLE,
    input wire logic LOADER_START,
    input wire logic [1:0] PROTECT_LEVEL,
    input wire logic READY,
    input wire logic LOADER_CMD_VALID,
    input wire logic LOADER_CMD_ACCEPT,
    input wire logic LOADER_CMD_REJECT,
    input wire logic IN_APPLICATION_PROGRAMMING_VALID,
    input wire logic IN_APPLICATION_PROGRAMMING_REINVOKE,
    input wire logic IN_APPLICATION_PROGRAMMING_ACCEPT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    // Pattern word taken on this edge
    wire logic take = PAT_RD_REQ && PAT_RD_VALID;
    a_fetch_once: assert property (take |=> !PAT_RD_REQ)
        else $error("pattern fetch repeated");
    a_partial_lvl: assert property (take && PAT_RD_DATA == protect_pkg::PAT_PARTIAL_UPDATE
        |=> PROTECT_LEVEL == 2'h1) else $error("level one not set");
    a_erase_lvl: assert property (take && PAT_RD_DATA == protect_pkg::PAT_FULL_ERASE_ONLY
        |=> PROTECT_LEVEL == 2'h2) else $error("level two not set");
    a_locked_lvl: assert property (take && PAT_RD_DATA == protect_pkg::PAT_LOCKED
        |=> PROTECT_LEVEL == 2'h3) else $error("level three not set");
    a_no_entry: assert property (take && PAT_RD_DATA == protect_pkg::PAT_NO_LOADER_ENTRY
        |=> PROTECT_LEVEL == 2'h0) else $error("loader lockout set a level");
    a_debug_gate: assert property (DEBUG_ENABLE |-> READY && PROTECT_LEVEL == 2'h0)
        else $error("debug open while protected");
    a_one_answer: assert property (LOADER_CMD_VALID |-> LOADER_CMD_ACCEPT != LOADER_CMD_REJECT)
        else $error("loader answer not unique");
    a_locked_refuse: assert property (LOADER_CMD_VALID && PROTECT_LEVEL == 2'h3
        |-> LOADER_CMD_REJECT) else $error("locked level accepted");
    a_app_open: assert property (IN_APPLICATION_PROGRAMMING_VALID && READY
        |-> IN_APPLICATION_PROGRAMMING_ACCEPT) else $error("application call refused");
    a_reinvoke_start: assert property (IN_APPLICATION_PROGRAMMING_VALID && READY
        && IN_APPLICATION_PROGRAMMING_REINVOKE |=> LOADER_START)
        else $error("reinvoke gave no start");
endmodule : code_read_protection_gate_sva
bind code_read_protection_gate code_read_protection_gate_sva chk (.REF_CLK, .SYS_RST,
    .PAT_RD_REQ, .PAT_RD_VALID, .PAT_RD_DATA, .DEBUG_ENABLE, .LOADER_START, .PROTECT_LEVEL,
    .READY, .LOADER_CMD_VALID, .LOADER_CMD_ACCEPT, .LOADER_CMD_REJECT,
    .IN_APPLICATION_PROGRAMMING_VALID, .IN_APPLICATION_PROGRAMMING_REINVOKE,
    .IN_APPLICATION_PROGRAMMING_ACCEPT);
`default_nettype wire

// *** flash_pattern_model.sv ***
// Flash array model answering the protection pattern fetch
`timescale 1ns/100ps
`default_nettype none
module flash_pattern_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [31:0] word,
    input wire logic [3:0] delay,
    output logic valid,
    output logic [31:0] data
);
    logic [3:0] wait_reg;
    // Answer a pending fetch after a chosen delay
    always_ff @(posedge clk)
    begin
        if (rst || !req || valid)
        begin
            wait_reg <= 4'h0;
            valid <= 1'b0;
        end
        else
        begin
            wait_reg <= wait_reg + 4'h1;
            valid <= (wait_reg == delay);
        end
    end
    // Word only while valid, inverted filler otherwise
    assign data = valid ? word : ~word;
endmodule : flash_pattern_model
`default_nettype wire

// *** test_code_read_protection_gate.sv ***
// Self-checking bench for the code read protection gate
`timescale 1ns/100ps
`default_nettype none
module test_code_read_protection_gate;
    logic clk = 1'b0, rst = 1'b1, pin = 1'b0, lv = 1'b0, iv = 1'b0, ir = 1'b0;
    logic req, valid, de, ls, rdy, acc, rej, iacc, erased;
    logic [1:0] lvl;
    logic [3:0] dly = 4'h0;
    logic [31:0] word = 32'h0, data, addr, seed = 32'h59, r;
    logic [31:0] pats [6];
    logic [1:0] exp_lvl [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
    logic exp_start [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    protect_pkg::loader_cmd_t cmd = '0, c;
    int mismatches = 0, n_checks = 0, n;
    always #5 clk = ~clk;
    code_read_protection_gate dut (.REF_CLK(clk), .SYS_RST(rst), .PAT_RD_REQ(req),
        .PAT_RD_ADDR(addr), .PAT_RD_VALID(valid), .PAT_RD_DATA(data), .BOOT_SELECT_PIN(pin),
        .DEBUG_ENABLE(de), .LOADER_START(ls), .PROTECT_LEVEL(lvl), .READY(rdy),
        .LOADER_CMD_VALID(lv), .LOADER_CMD(cmd), .LOADER_CMD_ACCEPT(acc),
        .LOADER_CMD_REJECT(rej), .IN_APPLICATION_PROGRAMMING_VALID(iv),
        .IN_APPLICATION_PROGRAMMING_REINVOKE(ir), .IN_APPLICATION_PROGRAMMING_ACCEPT(iacc));
    flash_pattern_model flash (.clk(clk), .rst(rst), .req(req), .word(word), .delay(dly),
        .valid(valid), .data(data));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Loader command verdict per level
    function automatic logic exp_acc(input logic [1:0] l, input protect_pkg::loader_cmd_t k);
        if (l == 2'h0)
            return 1'b1;
        if (l == 2'h1)
            return k.sector != 4'h0 && !(k.code inside {protect_pkg::CMD_READ,
                protect_pkg::CMD_GO, protect_pkg::CMD_ERASE_ALL, protect_pkg::CMD_BLANK_CHECK});
        if (l == 2'h2)
            return k.code == protect_pkg::CMD_ERASE_ALL || erased;
        return 1'b0;
    endfunction : exp_acc
    task automatic compare(input logic [1:0] got, input logic [1:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : compare
    // Word compare for the fetch address
    task automatic compare_addr(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : compare_addr
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // Main sequence: one startup and loader session per pattern
    initial
    begin
        pats = '{protect_pkg::PAT_PARTIAL_UPDATE, protect_pkg::PAT_FULL_ERASE_ONLY,
            protect_pkg::PAT_LOCKED, protect_pkg::PAT_NO_LOADER_ENTRY,
            (rnd() << 4) | 32'h0000000E, 32'h00000000};
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            rst <= 1'b1;
            pin <= (i == 5);
            word <= pats[i];
            dly <= 4'(rnd() % 8);
            cmd <= '{protect_pkg::CMD_READ, 4'h1, 1'b0};
            repeat (4) @(posedge clk);
            rst <= 1'b0;
            lv <= 1'b1;
            n = 0;
            do
            begin
                @(posedge clk);
                #1 compare(acc, 1'b0, "command before start");
                if (req)
                    compare_addr(addr, protect_pkg::PAT_ADDR, "pattern address");
                n++;
                if (n > 40)
                begin
                    mismatches++;
                    end_sim();
                end
            end
            while (rdy !== 1'b1);
            compare(lvl, exp_lvl[i], "level");
            compare(ls, exp_start[i], "loader start");
            compare(de, exp_lvl[i] == 2'h0, "debug enable");
            @(posedge clk);
            pin <= 1'b1;
            lv <= 1'b0;
            iv <= 1'b1;
            ir <= 1'b1;
            #1 compare(iacc, 1'b1, "application call");
            @(posedge clk);
            iv <= 1'b0;
            #1 compare(ls, 1'b1, "reinvoke start");
            erased = 1'b0;
            repeat (12)
            begin
                @(posedge clk);
                r = rnd();
                c.code = exp_lvl[i] == 2'h2 ? (r[1] ? protect_pkg::CMD_WRITE : r[0] ?
                    protect_pkg::CMD_COPY_RAM : protect_pkg::CMD_ERASE_ALL) : 4'(r % 10);
                c.sector = r[7:4];
                c.whole_chip = exp_lvl[i] == 2'h2 && c.code == protect_pkg::CMD_ERASE_ALL;
                cmd <= c;
                lv <= 1'b1;
                #1 compare(acc, exp_acc(exp_lvl[i], c), "loader verdict");
                erased = erased | (exp_acc(exp_lvl[i], c)
                    && c.code == protect_pkg::CMD_ERASE_ALL);
            end
            @(posedge clk);
            lv <= 1'b0;
            $display("test %0d done", i);
        end
        end_sim();
    end
endmodule : test_code_read_protection_gate
`default_nettype wire
